// File: sbc_ctrl_pkg.sv
/*
 * constants for the transceiver mode and wake source control registers:
 * register offsets, reset and restart values, field positions, mode codes.
 * assumes a 7-bit register address and 8-bit register data on the device
 * side of the serial interface; frame decoding happens outside this block.
 */
// How it works
// - bus control bits 7:3 always read zero
// - bits 2:0 pick mode, lower two hardware-writable
// - top mode bit set adds selective wake
// - hardware changes the selective wake bit only on a reset or restart load
// - sleep entry without system error: x11 becomes x01
// - x10 wakes capable on sleep, stays on stop
// - off or wake capable untouched on low power
// - failure fail-safe forces bus control to 0000_0x01
// - development mode reset gives normal mode 011
// - reset zeros bus control, restart loads cause code
// - internal bit 6 enables cyclic timer wake
// - internal bit 2 disables watchdog in stop
// - stop to normal clears watchdog disable bit
// - internal register reset zero, restart keeps bit 6
// - external bit 7 routes all status to interrupt
// - external bit 5 selects voltage sensing, no wake
// - external reset 01, restart keeps bits 7,5,0
// - external bit 0 enables the wake input
// - fail-safe without sensing rewrites external to x0x0_0001
// - sensing select refused while failure output active
package sbc_ctrl_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [6:0] BUS_CTRL_OFF = 7'h04;
   localparam logic [6:0] INT_WAKE_OFF = 7'h06;
   localparam logic [6:0] EXT_WAKE_OFF = 7'h07;

   // ****************************************************************
   // reset values and writable masks
   // ****************************************************************
   localparam logic [7:0] BUS_CTRL_RST  = 8'h00;
   localparam logic [7:0] INT_WAKE_RST  = 8'h00;
   localparam logic [7:0] EXT_WAKE_RST  = 8'h01;
   localparam logic [7:0] BUS_CTRL_MASK = 8'h07;
   localparam logic [7:0] INT_WAKE_MASK = 8'h44;
   localparam logic [7:0] EXT_WAKE_MASK = 8'hA1;
   localparam logic [7:0] INT_RESTART_KEEP = 8'h40;
   localparam logic [7:0] EXT_RESTART_KEEP = 8'hA1;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int SELECTIVE_WAKE_BIT  = 2;
   localparam int TIMER_WAKE_BIT      = 6;
   localparam int STOP_WD_DISABLE_BIT = 2;
   localparam int INT_GLOBAL_BIT      = 7;
   localparam int VSENSE_SELECT_BIT   = 5;
   localparam int WAKE_INPUT_BIT      = 0;

   // ****************************************************************
   // transceiver mode codes, lower two bits of the mode field, and the 3-bit development reset mode
   // ****************************************************************
   localparam logic [1:0] CAN_OFF       = 2'h0;
   localparam logic [1:0] CAN_WAKE_CAP  = 2'h1;
   localparam logic [1:0] CAN_RX_ONLY   = 2'h2;
   localparam logic [1:0] CAN_NORMAL    = 2'h3;
   localparam logic [2:0] DEV_MODE_INIT = 3'h3;

endpackage

// File: wake_irq_gate.sv
/*
 * wake source gating and interrupt output: turns raw wake and status
 * events into a registered wake pulse and an active-low interrupt pulse.
 * assumes all event inputs are one-cycle pulses synchronous to mclk_i.
 */
module wake_irq_gate (
   // clock, reset, enable
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   input  wire logic ce_i,
   // configuration from the control registers
   input  wire logic timer_wake_enable_i,
   input  wire logic wake_input_enable_i,
   input  wire logic voltage_sense_select_i,
   input  wire logic int_global_i,
   // raw events
   input  wire logic hv_wake_event_i,
   input  wire logic timer_event_i,
   input  wire logic bus_wake_event_i,
   input  wire logic status_event_i,
   // gated results
   output logic      wake_event_o,
   output logic      interrupt_output_n_o
);

   logic next_wake;
   logic next_irq;

   // sensing mode steals the input, so no wake may come from it
   always_comb begin
      next_wake = (hv_wake_event_i & wake_input_enable_i & ~voltage_sense_select_i)
                | (timer_event_i & timer_wake_enable_i)
                | bus_wake_event_i;
      next_irq  = next_wake | (int_global_i & status_event_i);
   end

   // registered so the pins never glitch
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wake_event_o         <= 1'b0;
         interrupt_output_n_o <= 1'b1;
      end else if (ce_i) begin
         wake_event_o         <= next_wake;
         interrupt_output_n_o <= ~next_irq;
      end
   end

   chk_status_gated: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ce_i && status_event_i && !int_global_i && !hv_wake_event_i && !timer_event_i
      && !bus_wake_event_i |=> interrupt_output_n_o)
      else $error("status event reached interrupt with global select low");

endmodule // wake_irq_gate

// File: sbc_mode_regs.sv
/*
 * transceiver mode, internal wake and external wake control registers of
 * the system basis chip, with the hardware rewrites on mode transitions.
 * assumes the serial interface delivers decoded one-cycle read and write
 * strobes, and the mode controller delivers one-cycle entry pulses.
 */
module sbc_mode_regs (
   // clock, reset, enable
   input  wire logic       mclk_i,
   input  wire logic       nrst_i,
   input  wire logic       ce_i,
   // decoded register access
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [6:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   output logic            spi_fail_o,
   // mode controller events
   input  wire logic       soft_reset_i,
   input  wire logic       dev_mode_i,
   input  wire logic       restart_entry_i,
   input  wire logic [2:0] restart_can_mode_i,
   input  wire logic       sleep_entry_i,
   input  wire logic       stop_entry_i,
   input  wire logic       stop_to_normal_i,
   input  wire logic       failsafe_entry_i,
   input  wire logic       system_error_flag_i,
   input  wire logic       failure_output_i,
   // raw wake and status events
   input  wire logic       high_voltage_wake_input_i,
   input  wire logic       timer_event_i,
   input  wire logic       bus_wake_event_i,
   input  wire logic       status_event_i,
   // configuration outputs
   output logic      [2:0] can_mode_o,
   output logic            timer_wake_enable_o,
   output logic            stop_watchdog_disable_b1_o,
   output logic            int_global_o,
   output logic            voltage_sense_select_o,
   output logic            wake_input_enable_o,
   // gated wake and interrupt
   output logic            wake_event_o,
   output logic            interrupt_output_n_o
);

   // ****************************************************************
   // storage and decode
   // ****************************************************************
   logic [7:0] bus_ctrl;
   logic [7:0] int_wake;
   logic [7:0] ext_wake;
   logic       init_pend;
   logic       hw_force;
   logic       wr_bus;
   logic       wr_int;
   logic       wr_ext;
   logic       vss_refuse;

   // forced loads override every ordinary write, except that fail-safe lets an internal wake write through
   assign hw_force   = init_pend | soft_reset_i | failsafe_entry_i | restart_entry_i;
   assign wr_bus     = reg_wr_i && reg_addr_i == sbc_ctrl_pkg::BUS_CTRL_OFF;
   assign wr_int     = reg_wr_i && reg_addr_i == sbc_ctrl_pkg::INT_WAKE_OFF;
   assign wr_ext     = reg_wr_i && reg_addr_i == sbc_ctrl_pkg::EXT_WAKE_OFF;
   assign vss_refuse = wr_ext & failure_output_i
                     & reg_wdata_i[sbc_ctrl_pkg::VSENSE_SELECT_BIT]
                     & ~ext_wake[sbc_ctrl_pkg::VSENSE_SELECT_BIT];

   // development strap is sampled on the first enabled edge after reset,
   // since an async reset may only load a constant
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         init_pend <= 1'b1;
      end else if (ce_i) begin
         init_pend <= 1'b0;
      end
   end

   // ****************************************************************
   // transceiver mode register
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus_ctrl <= sbc_ctrl_pkg::BUS_CTRL_RST;
      end else if (ce_i) begin
         if (init_pend || soft_reset_i) begin
            bus_ctrl <= dev_mode_i ? {5'h00, sbc_ctrl_pkg::DEV_MODE_INIT}
                                   : sbc_ctrl_pkg::BUS_CTRL_RST;
         end else if (failsafe_entry_i) begin
            // selective wake belongs to the host, so even fail-safe leaves it
            bus_ctrl <= {5'h00, bus_ctrl[2], sbc_ctrl_pkg::CAN_WAKE_CAP};
         end else if (restart_entry_i) begin
            bus_ctrl <= {5'h00, restart_can_mode_i};
         end else if (sleep_entry_i) begin
            // only the low pair moves; selective wake stays with the host
            if ((bus_ctrl[1:0] == sbc_ctrl_pkg::CAN_NORMAL && !system_error_flag_i)
                || bus_ctrl[1:0] == sbc_ctrl_pkg::CAN_RX_ONLY) begin
               bus_ctrl[1:0] <= sbc_ctrl_pkg::CAN_WAKE_CAP;
            end
         end else if (stop_entry_i) begin
            bus_ctrl <= bus_ctrl;
         end else if (wr_bus) begin
            bus_ctrl <= reg_wdata_i & sbc_ctrl_pkg::BUS_CTRL_MASK;
         end
      end
   end

   // ****************************************************************
   // internal wake control register
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         int_wake <= sbc_ctrl_pkg::INT_WAKE_RST;
      end else if (ce_i) begin
         if (init_pend || soft_reset_i) begin
            int_wake <= sbc_ctrl_pkg::INT_WAKE_RST;
         end else if (restart_entry_i) begin
            int_wake <= int_wake & sbc_ctrl_pkg::INT_RESTART_KEEP;
         end else if (stop_to_normal_i) begin
            // the mode change wins over a host write to bit 2 in the same cycle; bit 6 still takes the write
            int_wake[sbc_ctrl_pkg::STOP_WD_DISABLE_BIT] <= 1'b0;
            if (wr_int) begin
               int_wake[sbc_ctrl_pkg::TIMER_WAKE_BIT] <=
                  reg_wdata_i[sbc_ctrl_pkg::TIMER_WAKE_BIT];
            end
         end else if (wr_int) begin
            int_wake <= reg_wdata_i & sbc_ctrl_pkg::INT_WAKE_MASK;
         end
      end
   end

   // ****************************************************************
   // external wake control register
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_wake <= sbc_ctrl_pkg::EXT_WAKE_RST;
      end else if (ce_i) begin
         if (init_pend || soft_reset_i) begin
            ext_wake <= sbc_ctrl_pkg::EXT_WAKE_RST;
         end else if (failsafe_entry_i) begin
            // with sensing selected the input cannot serve as a wake source
            if (!ext_wake[sbc_ctrl_pkg::VSENSE_SELECT_BIT]) begin
               ext_wake <= (ext_wake & 8'hA0) | 8'h01;
            end
         end else if (restart_entry_i) begin
            ext_wake <= ext_wake & sbc_ctrl_pkg::EXT_RESTART_KEEP;
         end else if (wr_ext) begin
            ext_wake <= reg_wdata_i & sbc_ctrl_pkg::EXT_WAKE_MASK;
            if (vss_refuse) begin
               ext_wake[sbc_ctrl_pkg::VSENSE_SELECT_BIT] <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // read port and failure flag
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= sbc_ctrl_pkg::UNMAPPED_READ;
      end else if (ce_i && reg_rd_i) begin
         unique case (reg_addr_i)
            sbc_ctrl_pkg::BUS_CTRL_OFF: reg_rdata_o <= bus_ctrl;
            sbc_ctrl_pkg::INT_WAKE_OFF: reg_rdata_o <= int_wake;
            sbc_ctrl_pkg::EXT_WAKE_OFF: reg_rdata_o <= ext_wake;
            default:                    reg_rdata_o <= sbc_ctrl_pkg::UNMAPPED_READ;
         endcase
      end
   end

   // one-cycle pulse; the interface logic keeps the sticky copy
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         spi_fail_o <= 1'b0;
      end else if (ce_i) begin
         spi_fail_o <= vss_refuse & ~hw_force;
      end
   end

   // ****************************************************************
   // configuration outputs, all straight from the registers
   // ****************************************************************
   assign can_mode_o                 = bus_ctrl[2:0];
   assign timer_wake_enable_o        = int_wake[sbc_ctrl_pkg::TIMER_WAKE_BIT];
   assign stop_watchdog_disable_b1_o = int_wake[sbc_ctrl_pkg::STOP_WD_DISABLE_BIT];
   assign int_global_o               = ext_wake[sbc_ctrl_pkg::INT_GLOBAL_BIT];
   assign voltage_sense_select_o     = ext_wake[sbc_ctrl_pkg::VSENSE_SELECT_BIT];
   assign wake_input_enable_o        = ext_wake[sbc_ctrl_pkg::WAKE_INPUT_BIT];

   // gated wake sources and interrupt pin
   wake_irq_gate u_gate (
      .mclk_i                 (mclk_i),
      .nrst_i                 (nrst_i),
      .ce_i                   (ce_i),
      .timer_wake_enable_i    (int_wake[sbc_ctrl_pkg::TIMER_WAKE_BIT]),
      .wake_input_enable_i    (ext_wake[sbc_ctrl_pkg::WAKE_INPUT_BIT]),
      .voltage_sense_select_i (ext_wake[sbc_ctrl_pkg::VSENSE_SELECT_BIT]),
      .int_global_i           (ext_wake[sbc_ctrl_pkg::INT_GLOBAL_BIT]),
      .hv_wake_event_i        (high_voltage_wake_input_i),
      .timer_event_i          (timer_event_i),
      .bus_wake_event_i       (bus_wake_event_i),
      .status_event_i         (status_event_i),
      .wake_event_o           (wake_event_o),
      .interrupt_output_n_o   (interrupt_output_n_o)
   );

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   chk_bus_reserved_zero: assert property (bus_ctrl[7:3] == 5'h00)
      else $error("reserved bus control bits not zero");

   chk_swk_hw_hold: assert property (
      ce_i && !hw_force && !wr_bus |=> $stable(bus_ctrl[2]))
      else $error("selective wake bit changed without host write");

   chk_sleep_normal: assert property (
      ce_i && !hw_force && sleep_entry_i && !system_error_flag_i
      && bus_ctrl[1:0] == 2'h3 |=> bus_ctrl[1:0] == 2'h1 && $stable(bus_ctrl[2]))
      else $error("normal mode not moved to wake capable on sleep");

   chk_stop_rx_only: assert property (
      ce_i && !hw_force && !sleep_entry_i && stop_entry_i
      && bus_ctrl[1:0] == 2'h2 |=> bus_ctrl[1:0] == 2'h2)
      else $error("receive only lost on stop entry");

   chk_lowpower_keep: assert property (
      ce_i && !hw_force && (sleep_entry_i || stop_entry_i) && !bus_ctrl[1]
      |=> $stable(bus_ctrl))
      else $error("off or wake capable mode altered on low power entry");

   chk_failsafe_bus: assert property (
      ce_i && !init_pend && !soft_reset_i && failsafe_entry_i
      |=> bus_ctrl == {5'h00, $past(bus_ctrl[2]), 2'h1}
      ##1 !ce_i || $stable(bus_ctrl) || $past(hw_force | wr_bus | sleep_entry_i))
      else $error("fail-safe did not force bus control to wake capable");

   chk_wd_clear: assert property (
      ce_i && !init_pend && !soft_reset_i && !restart_entry_i && stop_to_normal_i
      |=> !stop_watchdog_disable_b1_o)
      else $error("stop watchdog disable bit not cleared on stop exit");

   chk_restart_int: assert property (
      ce_i && !init_pend && !soft_reset_i && restart_entry_i
      |=> int_wake == {1'b0, $past(int_wake[6]), 6'h00})
      else $error("internal wake register wrong after restart");

   chk_failsafe_ext: assert property (
      ce_i && !init_pend && !soft_reset_i && failsafe_entry_i && !ext_wake[5]
      |=> ext_wake == {$past(ext_wake[7]), 7'h01})
      else $error("external wake register not rewritten on fail-safe");

   chk_vss_refused: assert property (
      ce_i && !hw_force && vss_refuse |=> !voltage_sense_select_o && spi_fail_o)
      else $error("sensing select accepted while failure output active");

   chk_sleep_rx_only: assert property (
      ce_i && !hw_force && sleep_entry_i
      && bus_ctrl[1:0] == 2'h2 |=> bus_ctrl[1:0] == 2'h1 && $stable(bus_ctrl[2]))
      else $error("receive only not moved to wake capable on sleep");

   // the strap is only looked at on a reset load, never while running
   chk_dev_reset: assert property (
      ce_i && (init_pend || soft_reset_i) && dev_mode_i |=> bus_ctrl == 8'h03)
      else $error("development mode reset did not select normal mode");

   chk_soft_reset_wake: assert property (
      ce_i && (init_pend || soft_reset_i)
      |=> int_wake == 8'h00 && ext_wake == 8'h01)
      else $error("wake control registers not at reset values");

   // restart keeps the host's wake routing, fail-safe in the same cycle wins
   chk_restart_ext: assert property (
      ce_i && !init_pend && !soft_reset_i && !failsafe_entry_i && restart_entry_i
      |=> ext_wake == ($past(ext_wake) & 8'hA1))
      else $error("external wake register wrong after restart");

   chk_restart_bus: assert property (
      ce_i && !init_pend && !soft_reset_i && !failsafe_entry_i && restart_entry_i
      |=> bus_ctrl == {5'h00, $past(restart_can_mode_i)})
      else $error("bus control wrong after restart");

   // reserved positions stay zero whatever the host or a forced load writes
   chk_reserved_wake: assert property (
      int_wake[7] == 1'b0 && int_wake[5:3] == 3'h0 && int_wake[1:0] == 2'h0
      && ext_wake[6] == 1'b0 && ext_wake[4:1] == 4'h0)
      else $error("reserved wake control bits not zero");

   // ****************************************************************
   // coverage of the main scenarios
   // ****************************************************************
   cov_sleep_rewrite: cover property (
      ce_i && !hw_force && sleep_entry_i && bus_ctrl[1:0] == 2'h3 ##1 bus_ctrl[1:0] == 2'h1);
   cov_failsafe: cover property (ce_i && failsafe_entry_i && !init_pend);
   cov_refused: cover property (spi_fail_o);
   cov_stop_clear: cover property (ce_i && stop_to_normal_i && int_wake[2]);
   cov_restart: cover property (ce_i && restart_entry_i && !init_pend);

endmodule // sbc_mode_regs

// File: host_model.sv
/*
 * host microcontroller model: issues decoded register writes and reads
 * toward the mode and wake control registers.
 * assumes one-cycle strobes taken on the rising clock edge and read data
 * picked up at the falling edge after the taking edge.
 */
module host_model (
   // clock
   input  wire logic       mclk_i,
   // register access toward the device
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [6:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o,
   // read data from the device
   input  wire logic [7:0] reg_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // idle state and access tasks
   // ****************************************************************
   // idle lines carry a scrambled value so a stale write never looks valid
   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = 7'h7f;
      reg_wdata_o = 8'ha5;
   end

   // one write, strobe held over exactly one taking edge
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = 1'b1;
      @(negedge mclk_i);
      reg_wr_o    = 1'b0;
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask

   // one read, data picked up once the answer cycle has settled
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge mclk_i);
      reg_addr_o = a;
      reg_rd_o   = 1'b1;
      @(negedge mclk_i);
      reg_rd_o   = 1'b0;
      reg_addr_o = ~a;
      d          = reg_rdata_i;
   endtask
endmodule // host_model

// File: testbench.sv
/*
 * self-checking bench for the transceiver mode and wake control registers.
 * assumes sbc_mode_regs as top and host_model as the register master;
 * mode events are one-cycle pulses driven on the falling edge.
 */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // stimulus and observed signals
   // ****************************************************************
   localparam int SOFT = 0, RESTART = 1, SLEEP = 2, STOP = 3, TO_NORMAL = 4;
   localparam int FAILSAFE = 5, HV = 6, TIMER = 7, BUSWK = 8, STATUS = 9;
   logic       mclk, nrst, ce, dev_mode, system_error_flag, fail_out;
   logic [2:0] restart_mode, can_mode;
   logic [9:0] ev;
   logic       reg_wr, reg_rd, spi_fail, timer_en, wd_dis, glob, vsense, wake_input_enable;
   logic       wake, intr_n;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   int         n_mismatch, samples_checked;

   sbc_mode_regs sbc_mode_regs_inst (
      .mclk_i(mclk), .nrst_i(nrst), .ce_i(ce),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .spi_fail_o(spi_fail),
      .soft_reset_i(ev[SOFT]), .dev_mode_i(dev_mode), .restart_entry_i(ev[RESTART]),
      .restart_can_mode_i(restart_mode), .sleep_entry_i(ev[SLEEP]),
      .stop_entry_i(ev[STOP]), .stop_to_normal_i(ev[TO_NORMAL]),
      .failsafe_entry_i(ev[FAILSAFE]), .system_error_flag_i(system_error_flag),
      .failure_output_i(fail_out), .high_voltage_wake_input_i(ev[HV]),
      .timer_event_i(ev[TIMER]), .bus_wake_event_i(ev[BUSWK]),
      .status_event_i(ev[STATUS]), .can_mode_o(can_mode),
      .timer_wake_enable_o(timer_en), .stop_watchdog_disable_b1_o(wd_dis),
      .int_global_o(glob), .voltage_sense_select_o(vsense),
      .wake_input_enable_o(wake_input_enable), .wake_event_o(wake), .interrupt_output_n_o(intr_n));

   host_model host_model_inst (
      .mclk_i(mclk), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host_model_inst.rd(a, d);
      chk($sformatf("reg %h", a), d, exp);
   endtask

   // one-cycle mode or wake event; its effect is settled on return
   task automatic pulse(input int idx);
      @(negedge mclk);
      ev[idx] = 1'b1;
      @(negedge mclk);
      ev = '0;
   endtask

   task automatic evchk(input int idx, input logic ew, input logic ei);
      pulse(idx);
      chk("wake event", {7'h00, wake}, {7'h00, ew});
      chk("interrupt", {7'h00, intr_n}, {7'h00, ei});
   endtask

   task automatic finish_test;
      $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset_and_reserved;
      rchk(7'h04, 8'h00);
      rchk(7'h06, 8'h00);
      rchk(7'h07, 8'h01);
      rchk(7'h05, 8'h00);
      host_model_inst.wr(7'h04, 8'hff);
      host_model_inst.wr(7'h06, 8'hff);
      host_model_inst.wr(7'h07, 8'hff);
      rchk(7'h04, 8'h07);
      rchk(7'h06, 8'h44);
      rchk(7'h07, 8'ha1);
      chk("cfg", {timer_en, wd_dis, glob, vsense, wake_input_enable, can_mode}, 8'hff);
   endtask

   task automatic t_mode_codes;
      for (int c = 0; c < 8; c++) begin
         host_model_inst.wr(7'h04, 8'(c));
         rchk(7'h04, 8'(c));
      end
   endtask

   // sleep folds x1x to x01, except x11 under a system error; stop keeps everything but the unlisted x11
   task automatic t_low_power;
      logic [2:0] c;
      system_error_flag = 1'b0;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         host_model_inst.wr(7'h04, {5'h00, c});
         pulse(SLEEP);
         rchk(7'h04, {5'h00, c[1] ? {c[2], 2'b01} : c});
         if (c[1:0] != 2'b11) begin
            host_model_inst.wr(7'h04, {5'h00, c});
            pulse(STOP);
            rchk(7'h04, {5'h00, c});
         end
      end
      system_error_flag = 1'b1;
      host_model_inst.wr(7'h04, 8'h07);
      pulse(SLEEP);
      rchk(7'h04, 8'h07);
      system_error_flag = 1'b0;
   endtask

   task automatic t_failsafe_restart;
      host_model_inst.wr(7'h04, 8'h07);
      host_model_inst.wr(7'h07, 8'h80);
      pulse(FAILSAFE);
      rchk(7'h04, 8'h05);
      rchk(7'h07, 8'h81);
      host_model_inst.wr(7'h07, 8'ha0);
      pulse(FAILSAFE);
      rchk(7'h07, 8'ha0);
      host_model_inst.wr(7'h06, 8'h44);
      host_model_inst.wr(7'h07, 8'ha1);
      restart_mode = 3'b110;
      pulse(RESTART);
      rchk(7'h04, 8'h06);
      rchk(7'h06, 8'h40);
      rchk(7'h07, 8'ha1);
   endtask

   task automatic t_clear_refuse_dev;
      host_model_inst.wr(7'h06, 8'h44);
      pulse(TO_NORMAL);
      rchk(7'h06, 8'h40);
      host_model_inst.wr(7'h07, 8'h01);
      fail_out = 1'b1;
      host_model_inst.wr(7'h07, 8'ha1);
      chk("refused write flag", {7'h00, spi_fail}, 8'h01);
      rchk(7'h07, 8'h81);
      fail_out = 1'b0;
      dev_mode = 1'b1;
      pulse(SOFT);
      rchk(7'h04, 8'h03);
      rchk(7'h06, 8'h00);
      rchk(7'h07, 8'h01);
      dev_mode = 1'b0;
      pulse(SOFT);
      rchk(7'h04, 8'h00);
   endtask

   task automatic t_wake_sources;
      host_model_inst.wr(7'h06, 8'h00);
      host_model_inst.wr(7'h07, 8'h01);
      evchk(HV, 1'b1, 1'b0);
      evchk(TIMER, 1'b0, 1'b1);
      evchk(STATUS, 1'b0, 1'b1);
      host_model_inst.wr(7'h06, 8'h40);
      evchk(TIMER, 1'b1, 1'b0);
      host_model_inst.wr(7'h07, 8'h81);
      evchk(STATUS, 1'b0, 1'b0);
      host_model_inst.wr(7'h07, 8'h21);
      evchk(HV, 1'b0, 1'b1);
      host_model_inst.wr(7'h07, 8'h00);
      evchk(HV, 1'b0, 1'b1);
      evchk(BUSWK, 1'b1, 1'b0);
   endtask

   // ****************************************************************
   // clock, reset, sequence and watchdog
   // ****************************************************************
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // main sequence; reset released on a falling edge, init load let through
   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      nrst = 1'b0;
      ce = 1'b1;
      ev = '0;
      dev_mode = 1'b0;
      system_error_flag = 1'b0;
      fail_out = 1'b0;
      restart_mode = 3'b000;
      repeat (5) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      t_reset_and_reserved();
      t_mode_codes();
      t_low_power();
      t_failsafe_restart();
      t_clear_refuse_dev();
      t_wake_sources();
      finish_test();
   end

   // a few hundred cycles are needed; 5000 cycles, about twenty times that, means a hang
   initial begin
      #(25 * 5000);
      n_mismatch++;
      finish_test();
   end
endmodule // testbench
